// File: clock_time_base_pkg.sv
package clock_time_base_pkg;

    // width of the special function registers seen by the cpu
    localparam int SFR_WIDTH = 4;

    // time base counter: fifteen binary stages
    localparam int TBC_WIDTH = 15;
    localparam logic [14:0] TBC_RESET = 15'h0000;

    // stage index of each tapped output, stage n toggles at 16384/2**n hz
    localparam int TAP_4KHZ = 2;
    localparam int TAP_2KHZ = 3;
    localparam int TAP_256HZ = 6;
    localparam int TAP_128HZ = 7;
    localparam int TAP_64HZ = 8;
    localparam int TAP_32HZ = 9;
    localparam int TAP_16HZ = 10;
    localparam int TAP_8HZ = 11;
    localparam int TAP_4HZ = 12;
    localparam int TAP_2HZ = 13;
    localparam int TAP_1HZ = 14;

    // readout register shows stages 8 hz (bit 0) up to 1 hz (bit 3)
    localparam int READOUT_LSB = TAP_8HZ;
    localparam logic [14:0] READOUT_CLEAR_MASK = 15'h7800;

    // frequency control register layout
    localparam int FREQ_SEL_BIT = 0;
    localparam int FREQ_ACTIVE_BIT = 1;
    localparam logic [3:0] FREQ_CTRL_RESET = 4'h0;

    // time base interrupt request lines
    localparam int IRQ_256HZ = 0;
    localparam int IRQ_32HZ = 1;
    localparam int IRQ_16HZ = 2;
    localparam int IRQ_4HZ = 3;
    localparam int IRQ_1HZ = 4;
    localparam int IRQ_COUNT = 5;

    // buzzer tap bundle order
    localparam int BUZ_4KHZ = 0;
    localparam int BUZ_2KHZ = 1;
    localparam int BUZ_16HZ = 2;
    localparam int BUZ_8HZ = 3;
    localparam int BUZ_1HZ = 4;
    localparam int BUZ_COUNT = 5;

    // glitch free source switch states
    typedef enum logic [1:0] {
        MUX_XTAL,
        MUX_PARK_TO_RC,
        MUX_RC,
        MUX_PARK_TO_XTAL
    } mux_state_t;

endpackage : clock_time_base_pkg

// File: time_base_if.sv
`timescale 1ns/10ps
// link between the control top and the counter chain
interface time_base_if #(
    parameter int WIDTH = 15
);
    logic tick;               // one crystal falling edge
    logic clear;              // readout register write
    logic [WIDTH-1:0] count;  // stage states
    logic [WIDTH-1:0] fall;   // stages falling this cycle

    modport ctrl (
        output tick,
        output clear,
        input count,
        input fall
    );

    modport chain (
        input tick,
        input clear,
        output count,
        output fall
    );
endinterface : time_base_if

// File: time_base_chain.sv
`timescale 1ns/10ps
module time_base_chain
    import clock_time_base_pkg::*;
#(
    parameter int WIDTH = TBC_WIDTH
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    time_base_if.chain tb
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;
    logic [WIDTH-1:0] advanced;
    logic [WIDTH-1:0] clear_mask;

    // binary count, then the readout write forces the top four stages low
    assign clear_mask = WIDTH'(READOUT_CLEAR_MASK);
    assign advanced = tb.tick ? cnt_q + WIDTH'(1) : cnt_q; // R8 R10
    assign cnt_d = tb.clear ? (advanced & ~clear_mask) : advanced; // R18

    // a stage that was 1 and goes to 0 falls, whether by carry or by clear
    assign tb.fall = cnt_q & ~cnt_d; // R19
    assign tb.count = cnt_q;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q <= WIDTH'(TBC_RESET); // R9
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : time_base_chain

// File: clock_source_mux.sv
`timescale 1ns/10ps
module clock_source_mux
    import clock_time_base_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_xt_level,
    input wire logic i_rc_level,
    input wire logic i_select_rc,
    output logic o_sys_clk_q,
    output logic o_on_rc_q
);
    mux_state_t state_q;
    mux_state_t state_d;
    logic out_d;

    // the output is parked low between sources; a source is only left
    // and only taken while its level is low, so no pulse is ever cut short
    always_comb begin
        state_d = state_q;
        out_d = 1'b0;
        case (state_q)
            MUX_XTAL: begin
                out_d = i_xt_level; // R1
                if (i_select_rc && !i_xt_level) begin
                    state_d = MUX_PARK_TO_RC; // R22
                end
            end
            MUX_PARK_TO_RC: begin
                if (!i_select_rc && !i_xt_level) begin
                    state_d = MUX_XTAL;
                end else if (i_select_rc && !i_rc_level) begin
                    state_d = MUX_RC; // R22
                end
            end
            MUX_RC: begin
                out_d = i_rc_level; // R1
                if (!i_select_rc && !i_rc_level) begin
                    state_d = MUX_PARK_TO_XTAL; // R22
                end
            end
            MUX_PARK_TO_XTAL: begin
                if (i_select_rc && !i_rc_level) begin
                    state_d = MUX_RC;
                end else if (!i_select_rc && !i_xt_level) begin
                    state_d = MUX_XTAL; // R22
                end
            end
            default: begin
                state_d = MUX_XTAL;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= MUX_XTAL;
            o_sys_clk_q <= 1'b0;
            o_on_rc_q <= 1'b0;
        end else begin
            state_q <= state_d;
            o_sys_clk_q <= out_d;
            o_on_rc_q <= (state_d == MUX_RC);
        end
    end
endmodule : clock_source_mux

// File: clock_select_and_time_base.sv
`timescale 1ns/10ps
// Overview of operation
// R1: select bit 0 crystal, 1 rc source
// R2: crystal oscillator never stops for rc selection
// R3: rc oscillator runs only selected or test; code also keeps it on while the mux still sits on rc
// R4: select bit is bit 0, reset clears
// R5: selecting rc requests raised logic supply
// R6: software sets backup flag, waits 1 ms
// R7: software clears backup flag for low current
// R8: fifteen stage counter on crystal clock
// R9: counter starts from zero after reset
// R10: counter advances on crystal falling edge
// R11: interrupt on falls of 256,32,16,4,1 hz
// R12: 16 hz output feeds the watchdog
// R13: buzzer gets 1,8,16 hz, 4k, 2k
// R14: 64 hz output samples input ports
// R15: reset circuit gets 1 hz, 8 hz
// R16: capture gets 256,128,64,32 hz outputs
// R17: readout register reads 1 to 8 hz
// R18: any readout write clears 1-8 hz stages
// R19: clearing a set stage raises its request
// R20: software masks 1 hz before readout write
// R21: both registers are four bits wide
// R22: source switching makes no runt clock pulses
module clock_select_and_time_base
    import clock_time_base_pkg::*;
#(
    parameter int COUNT_WIDTH = TBC_WIDTH
) (
    input wire logic I_CLOCK,
    input wire logic I_NRST,
    // oscillator levels, already sampled to I_CLOCK
    input wire logic I_XT_LEVEL,
    input wire logic I_RC_LEVEL,
    input wire logic I_TEST_FAST_CLK_OUT,
    // special function register access from the cpu
    input wire logic I_FREQ_CTRL_WE,
    input wire logic I_TB_READOUT_WE,
    input wire logic [3:0] I_WDATA,
    output logic [3:0] O_FREQ_CTRL_RDATA,
    output logic [3:0] O_TB_READOUT_RDATA,
    // clock and oscillator control
    output logic O_SYS_CLK,
    output logic O_XT_OSC_EN,
    output logic O_RC_OSC_EN,
    output logic O_LOGIC_SUPPLY_BOOST,
    // time base outputs
    output logic [4:0] O_TB_IRQ,
    output logic O_WDT_16HZ,
    output logic [4:0] O_BUZZER_TAPS,
    output logic O_PORT_SAMPLE_64HZ,
    output logic O_RESET_1HZ,
    output logic O_RESET_8HZ,
    output logic [3:0] O_CAPTURE_TAPS
);

    time_base_if #(.WIDTH(COUNT_WIDTH)) tb ();

    // register state
    logic freq_sel_q;
    logic xt_prev_q;
    logic [IRQ_COUNT-1:0] irq_q;
    logic rc_en_q;
    logic boost_q;
    logic xt_en_q;
    logic [3:0] freq_rdata_q;
    logic [3:0] readout_rdata_q;

    // next values and decode
    logic freq_sel_d;
    logic xt_fall;
    logic [IRQ_COUNT-1:0] irq_d;
    logic rc_en_d;
    logic on_rc;
    logic [3:0] freq_rdata_d;
    logic [3:0] readout_rdata_d;
    logic [COUNT_WIDTH-1:0] count_w;
    logic [COUNT_WIDTH-1:0] fall_w;

    // ------------------------------------------------------------------
    // crystal edge detect; inputs are synchronous, so no synchroniser
    // ------------------------------------------------------------------
    assign xt_fall = xt_prev_q & ~I_XT_LEVEL; // R10

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            xt_prev_q <= 1'b0;
        end else begin
            xt_prev_q <= I_XT_LEVEL;
        end
    end

    // ------------------------------------------------------------------
    // counter chain hookup
    // ------------------------------------------------------------------
    assign tb.tick = xt_fall; // R8
    assign tb.clear = I_TB_READOUT_WE; // R18
    assign count_w = tb.count;
    assign fall_w = tb.fall;

    time_base_chain #(
        .WIDTH(COUNT_WIDTH)
    ) u_chain (
        .i_clk(I_CLOCK),
        .i_nrst(I_NRST),
        .tb(tb.chain)
    );

    // ------------------------------------------------------------------
    // frequency control register: only the select bit is writable
    // ------------------------------------------------------------------
    assign freq_sel_d = I_FREQ_CTRL_WE ? I_WDATA[FREQ_SEL_BIT] : freq_sel_q;

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            freq_sel_q <= FREQ_CTRL_RESET[FREQ_SEL_BIT]; // R4
        end else begin
            freq_sel_q <= freq_sel_d; // R4
        end
    end

    // ------------------------------------------------------------------
    // glitch free source switch; the mux picks the switch moment, and its on_rc also keeps the rc oscillator on
    // ------------------------------------------------------------------
    clock_source_mux u_mux (
        .i_clk(I_CLOCK),
        .i_nrst(I_NRST),
        .i_xt_level(I_XT_LEVEL),
        .i_rc_level(I_RC_LEVEL),
        .i_select_rc(freq_sel_q), // R1
        .o_sys_clk_q(O_SYS_CLK), // R22
        .o_on_rc_q(on_rc)
    );

    // ------------------------------------------------------------------
    // oscillator enables and supply request
    // the rc oscillator is kept alive while the mux still sits on it,
    // otherwise stopping it mid-switch could leave the mux parked forever
    // ------------------------------------------------------------------
    assign rc_en_d = freq_sel_q | I_TEST_FAST_CLK_OUT | on_rc; // R3

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            rc_en_q <= 1'b0;
            boost_q <= 1'b0;
            xt_en_q <= 1'b0;
        end else begin
            rc_en_q <= rc_en_d; // R3
            boost_q <= freq_sel_q; // R5
            xt_en_q <= 1'b1; // R2
        end
    end

    assign O_RC_OSC_EN = rc_en_q;
    assign O_LOGIC_SUPPLY_BOOST = boost_q;
    assign O_XT_OSC_EN = xt_en_q;

    // ------------------------------------------------------------------
    // time base interrupt requests: one cycle per falling stage output;
    // a readout write that clears a set stage falls it too
    // ------------------------------------------------------------------
    assign irq_d[IRQ_256HZ] = fall_w[TAP_256HZ]; // R11
    assign irq_d[IRQ_32HZ] = fall_w[TAP_32HZ]; // R11
    assign irq_d[IRQ_16HZ] = fall_w[TAP_16HZ]; // R11
    assign irq_d[IRQ_4HZ] = fall_w[TAP_4HZ]; // R11 R19
    assign irq_d[IRQ_1HZ] = fall_w[TAP_1HZ]; // R11 R19

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            irq_q <= '0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign O_TB_IRQ = irq_q;

    // ------------------------------------------------------------------
    // taps for the consumers come straight from the counter flops
    // ------------------------------------------------------------------
    assign O_WDT_16HZ = count_w[TAP_16HZ]; // R12
    assign O_BUZZER_TAPS[BUZ_4KHZ] = count_w[TAP_4KHZ]; // R13
    assign O_BUZZER_TAPS[BUZ_2KHZ] = count_w[TAP_2KHZ]; // R13
    assign O_BUZZER_TAPS[BUZ_16HZ] = count_w[TAP_16HZ]; // R13
    assign O_BUZZER_TAPS[BUZ_8HZ] = count_w[TAP_8HZ]; // R13
    assign O_BUZZER_TAPS[BUZ_1HZ] = count_w[TAP_1HZ]; // R13
    assign O_PORT_SAMPLE_64HZ = count_w[TAP_64HZ]; // R14
    assign O_RESET_1HZ = count_w[TAP_1HZ]; // R15
    assign O_RESET_8HZ = count_w[TAP_8HZ]; // R15
    assign O_CAPTURE_TAPS[0] = count_w[TAP_256HZ]; // R16
    assign O_CAPTURE_TAPS[1] = count_w[TAP_128HZ]; // R16
    assign O_CAPTURE_TAPS[2] = count_w[TAP_64HZ]; // R16
    assign O_CAPTURE_TAPS[3] = count_w[TAP_32HZ]; // R16

    // ------------------------------------------------------------------
    // read data, registered so the cpu sees a stable value; a read
    // therefore lags the stage states by one cycle
    // ------------------------------------------------------------------
    assign freq_rdata_d = {2'b00, on_rc, freq_sel_q}; // R21
    assign readout_rdata_d = count_w[READOUT_LSB +: SFR_WIDTH]; // R17 R21

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            freq_rdata_q <= FREQ_CTRL_RESET;
            readout_rdata_q <= 4'h0;
        end else begin
            freq_rdata_q <= freq_rdata_d;
            readout_rdata_q <= readout_rdata_d; // R17
        end
    end

    assign O_FREQ_CTRL_RDATA = freq_rdata_q;
    assign O_TB_READOUT_RDATA = readout_rdata_q;

endmodule : clock_select_and_time_base

// File: clock_select_and_time_base_chk.sv
`timescale 1ns/10ps
// port level checks, all on the system clock
module clock_select_and_time_base_chk (
    input wire logic I_CLOCK,
    input wire logic I_NRST,
    input wire logic I_TEST_FAST_CLK_OUT,
    input wire logic I_FREQ_CTRL_WE,
    input wire logic I_TB_READOUT_WE,
    input wire logic [3:0] I_WDATA,
    input wire logic [3:0] O_FREQ_CTRL_RDATA,
    input wire logic [3:0] O_TB_READOUT_RDATA,
    input wire logic O_XT_OSC_EN,
    input wire logic O_RC_OSC_EN,
    input wire logic O_LOGIC_SUPPLY_BOOST,
    input wire logic [4:0] O_TB_IRQ,
    input wire logic O_WDT_16HZ,
    input wire logic [4:0] O_BUZZER_TAPS,
    input wire logic O_PORT_SAMPLE_64HZ,
    input wire logic O_RESET_1HZ,
    input wire logic O_RESET_8HZ,
    input wire logic [3:0] O_CAPTURE_TAPS
);
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_NRST);
    // written select bit shows two edges after the write
    chk_sel_write: assert property (
        I_FREQ_CTRL_WE |-> ##2 O_FREQ_CTRL_RDATA[0] == $past(I_WDATA[0], 2))
        else $error("select bit not taken");
    chk_boost_sel: assert property (
        O_LOGIC_SUPPLY_BOOST == O_FREQ_CTRL_RDATA[0])
        else $error("boost differs from select");
    chk_rc_when_sel: assert property (
        O_FREQ_CTRL_RDATA[0] || $past(I_TEST_FAST_CLK_OUT) |-> O_RC_OSC_EN)
        else $error("rc oscillator off while needed");
    // first edge after release still shows the reset value
    chk_xt_running: assert property ($past(I_NRST) |-> O_XT_OSC_EN)
        else $error("crystal oscillator stopped");
    // the request flop loads in the same edge as the falling stage
    chk_irq_1hz: assert property ($fell(O_RESET_1HZ) |-> O_TB_IRQ[4])
        else $error("no 1 hz request");
    // a request lasting two cycles has no cause in its second cycle
    chk_irq_cause: assert property (
        O_TB_IRQ[0] |-> $past(O_CAPTURE_TAPS[0]) && !O_CAPTURE_TAPS[0])
        else $error("256 hz request without fall");
    chk_taps_shared: assert property (
        O_WDT_16HZ == O_BUZZER_TAPS[2] && O_RESET_8HZ == O_BUZZER_TAPS[3]
        && O_RESET_1HZ == O_BUZZER_TAPS[4]
        && O_PORT_SAMPLE_64HZ == O_CAPTURE_TAPS[2])
        else $error("shared taps disagree");
    chk_readout_clear: assert property (
        I_TB_READOUT_WE |=> (!O_RESET_1HZ && !O_RESET_8HZ)
        ##1 O_TB_READOUT_RDATA == 4'h0)
        else $error("readout write did not clear");
    chk_readout_map: assert property (
        O_TB_READOUT_RDATA[3] == $past(O_RESET_1HZ)
        && O_TB_READOUT_RDATA[0] == $past(O_RESET_8HZ))
        else $error("readout bits misplaced");
endmodule : clock_select_and_time_base_chk
bind clock_select_and_time_base clock_select_and_time_base_chk chk_u (
    .I_CLOCK, .I_NRST, .I_TEST_FAST_CLK_OUT, .I_FREQ_CTRL_WE,
    .I_TB_READOUT_WE, .I_WDATA, .O_FREQ_CTRL_RDATA, .O_TB_READOUT_RDATA,
    .O_XT_OSC_EN, .O_RC_OSC_EN, .O_LOGIC_SUPPLY_BOOST, .O_TB_IRQ,
    .O_WDT_16HZ, .O_BUZZER_TAPS, .O_PORT_SAMPLE_64HZ, .O_RESET_1HZ,
    .O_RESET_8HZ, .O_CAPTURE_TAPS);

// File: clock_sources_model.sv
`timescale 1ns/10ps
// oscillator levels seen by the block, one step per system clock
module clock_sources_model (
    input wire logic i_clk,
    input wire logic i_run,
    input wire logic i_rc_en,
    output logic o_xt,
    output logic o_rc
);
    logic [2:0] rc_cnt_q;
    initial begin
        o_xt = 1'b0;
        o_rc = 1'b0;
        rc_cnt_q = 3'h0;
    end
    // crystal parks high when paused so the tick count is unambiguous
    always @(posedge i_clk) begin
        if (i_run || !o_xt) o_xt <= !o_xt;
    end
    // rc source sits low while its enable is off, period six otherwise
    always @(posedge i_clk) begin
        rc_cnt_q <= (i_rc_en && rc_cnt_q < 3'h5) ? rc_cnt_q + 3'h1 : 3'h0;
        o_rc <= i_rc_en && rc_cnt_q < 3'h3;
    end
endmodule : clock_sources_model

// File: tb_clock_select_and_time_base.sv
`timescale 1ns/10ps
`define CHECK_EQ(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
    err_count++; $display("BAD %s exp %h got %h", nm, ex, got); end end
// random run lengths checked against a count of crystal falls
module tb_clock_select_and_time_base;
    logic I_CLOCK, I_NRST, I_TEST_FAST_CLK_OUT, I_FREQ_CTRL_WE;
    logic I_TB_READOUT_WE, I_XT_LEVEL, I_RC_LEVEL, O_SYS_CLK;
    logic O_XT_OSC_EN, O_RC_OSC_EN, O_LOGIC_SUPPLY_BOOST, O_WDT_16HZ;
    logic O_PORT_SAMPLE_64HZ, O_RESET_1HZ, O_RESET_8HZ, run, e4;
    logic [3:0] I_WDATA, O_FREQ_CTRL_RDATA, O_TB_READOUT_RDATA, O_CAPTURE_TAPS;
    logic [4:0] O_TB_IRQ, O_BUZZER_TAPS, seen;
    logic [14:0] cnt_m = 15'h0000;
    logic [14:0] cnt_p = 15'h0000;
    logic xt_prev = 1'b1;
    int err_count, n_tests, seed, n, it;
    clock_select_and_time_base dut_u (.I_CLOCK, .I_NRST, .I_XT_LEVEL,
        .I_RC_LEVEL, .I_TEST_FAST_CLK_OUT, .I_FREQ_CTRL_WE, .I_TB_READOUT_WE,
        .I_WDATA, .O_FREQ_CTRL_RDATA, .O_TB_READOUT_RDATA, .O_SYS_CLK,
        .O_XT_OSC_EN, .O_RC_OSC_EN, .O_LOGIC_SUPPLY_BOOST, .O_TB_IRQ,
        .O_WDT_16HZ, .O_BUZZER_TAPS, .O_PORT_SAMPLE_64HZ, .O_RESET_1HZ,
        .O_RESET_8HZ, .O_CAPTURE_TAPS);
    clock_sources_model osc_u (.i_clk(I_CLOCK), .i_run(run),
        .i_rc_en(O_RC_OSC_EN), .o_xt(I_XT_LEVEL), .o_rc(I_RC_LEVEL));
    initial begin
        I_CLOCK = 1'b0;
        forever #20 I_CLOCK = ~I_CLOCK;
    end
    // reference count; readout writes are only made while paused
    always @(posedge I_CLOCK) begin
        xt_prev <= I_XT_LEVEL;
        if (!I_NRST) cnt_m <= 15'h0000;
        else if (I_TB_READOUT_WE) cnt_m <= cnt_m & 15'h07FF;
        else if (xt_prev && !I_XT_LEVEL) cnt_m <= cnt_m + 15'h0001;
    end
    // request lines in port order from the stages that just fell
    function automatic logic [4:0] irq_of(input logic [14:0] f);
        return {f[14], f[12], f[10], f[9], f[6]};
    endfunction : irq_of
    // every cycle the requests must match the falls of the reference count
    always @(posedge I_CLOCK) cnt_p <= cnt_m;
    always @(negedge I_CLOCK) begin
        if (I_NRST) `CHECK_EQ("irq", irq_of(cnt_p & ~cnt_m), O_TB_IRQ)
    end
    function automatic logic [4:0] buzz_of(input logic [14:0] c);
        return {c[14], c[11], c[10], c[3], c[2]};
    endfunction : buzz_of
    task automatic cyc(input int k);
        repeat (k) @(posedge I_CLOCK);
    endtask : cyc
    task automatic wr(input logic sel, input logic [3:0] d);
        @(posedge I_CLOCK);
        I_FREQ_CTRL_WE <= sel;
        I_TB_READOUT_WE <= !sel;
        I_WDATA <= d;
        @(posedge I_CLOCK);
        I_FREQ_CTRL_WE <= 1'b0;
        I_TB_READOUT_WE <= 1'b0;
    endtask : wr
    task automatic check_taps();
        @(negedge I_CLOCK);
        `CHECK_EQ("capture", cnt_m[9:6], O_CAPTURE_TAPS)
        `CHECK_EQ("buzzer", buzz_of(cnt_m), O_BUZZER_TAPS)
        `CHECK_EQ("wdt port", cnt_m[10:9] & 2'h2 | {1'b0, cnt_m[8]},
            {O_WDT_16HZ, O_PORT_SAMPLE_64HZ})
        `CHECK_EQ("readout", cnt_m[14:11], O_TB_READOUT_RDATA)
    endtask : check_taps
    // counts rising edges of the system clock over sixty cycles
    task automatic rate(output int r);
        logic p;
        r = 0;
        p = O_SYS_CLK;
        repeat (60) begin
            @(negedge I_CLOCK);
            if (O_SYS_CLK && !p) r++;
            p = O_SYS_CLK;
        end
    endtask : rate
    task automatic report_and_stop();
        $display("mismatches %0d of %0d checks", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    initial begin
        // about 62k cycles are needed at worst, so this leaves a margin
        #(40 * 90000);
        err_count++;
        report_and_stop();
    end
    initial begin
        seed = 32'h68EC1930;
        {I_NRST, I_TEST_FAST_CLK_OUT, I_FREQ_CTRL_WE, I_TB_READOUT_WE} = 4'h0;
        run = 1'b0;
        I_WDATA = 4'h0;
        cyc(8);
        I_NRST <= 1'b1;
        check_taps();
        `CHECK_EQ("freq reset", 4'h0, O_FREQ_CTRL_RDATA)
        `CHECK_EQ("osc reset", 3'h0,
            {O_XT_OSC_EN, O_RC_OSC_EN, O_LOGIC_SUPPLY_BOOST})
        // the crystal enable comes up one edge after the release
        @(negedge I_CLOCK);
        `CHECK_EQ("osc release", 3'h4,
            {O_XT_OSC_EN, O_RC_OSC_EN, O_LOGIC_SUPPLY_BOOST})
        // early readout writes only, or the 1 hz stage would never set
        it = 0;
        while (cnt_m[14] !== 1'b1) begin
            run <= 1'b1;
            cyc(200 + {$random(seed)} % 1800);
            run <= 1'b0;
            cyc(6);
            check_taps();
            if (it < 3) begin
                wr(1'b0, 4'($random(seed)));
                cyc(3);
                check_taps();
            end
            it++;
        end
        // clearing a set 1 hz stage raises its request, 4 hz if set too
        e4 = cnt_m[12];
        seen = 5'h00;
        wr(1'b0, 4'($random(seed)));
        repeat (4) begin
            @(negedge I_CLOCK);
            seen = seen | O_TB_IRQ;
        end
        `CHECK_EQ("clear irq", {1'b1, e4, 3'h0}, seen)
        // a 1 ms wait of 25000 cycles passes before the fast select
        cyc(25000);
        // upper write bits are dropped, bit 1 reports the finished switch
        run <= 1'b1;
        wr(1'b1, 4'hF);
        cyc(30);
        rate(n);
        `CHECK_EQ("fast rdata", 4'h3, O_FREQ_CTRL_RDATA)
        `CHECK_EQ("fast osc", 3'h7,
            {O_XT_OSC_EN, O_RC_OSC_EN, O_LOGIC_SUPPLY_BOOST})
        `CHECK_EQ("fast rate", 1'b1, n >= 9 && n <= 11)
        wr(1'b1, 4'($random(seed)) & 4'hE);
        cyc(30);
        rate(n);
        `CHECK_EQ("slow rdata", 4'h0, O_FREQ_CTRL_RDATA)
        `CHECK_EQ("slow osc", 3'h4,
            {O_XT_OSC_EN, O_RC_OSC_EN, O_LOGIC_SUPPLY_BOOST})
        `CHECK_EQ("slow rate", 1'b1, n >= 28 && n <= 31)
        cyc(1);
        I_TEST_FAST_CLK_OUT <= 1'b1;
        cyc(3);
        @(negedge I_CLOCK);
        `CHECK_EQ("test rc", 2'h1, {O_FREQ_CTRL_RDATA[0], O_RC_OSC_EN})
        report_and_stop();
    end
endmodule : tb_clock_select_and_time_base
